// ### hdl/pxo_consts.svh
// constants of the pixel output and configuration set block
// Summary of operation
// - lookup table maps 12-bit codes to 12-bit codes, even for 8-bit output
// - 16-bit-output table entries are cut to 12 bits before storing
// - lookup table never changes line rate or data amount, usable in all modes
// - gamma curve value may be written at any time, also during acquisition
// - one table shared by all slots; upload refused while factory set is current slot
// - system gain applies to all lines, range 1x to 10x
// - each line has its own gain, range 1x to 4x
// - signed offset: negative subtracts before gain, positive lifts above zero
// - three-colour 8-bit is reset default, three rows per line, 100 kHz limit
// - mono 8-bit sends only enabled lines; 100, 150 or 300 kHz limit
// - both layouts send 8-bit pixels cut from the 12-bit result
// - connector one is master with control and data, connector two data only
// - next cable setting is held pending until power cycle or reconnection
// - sixteen non-volatile user slots besides the factory set
// - store writes active settings to the selected slot, which becomes current
// - restore copies the selected user slot or factory set into active settings
// - reset or power-up loads the boot slot into the active settings
// - active settings are volatile; unsaved changes are lost at reset
// - as shipped every user slot equals the factory set
`ifndef PXO_CONSTS_SVH
`define PXO_CONSTS_SVH
`define PXO_PIX_W        12
`define PXO_OUT_W        8
`define PXO_LUT_IN_W     12
`define PXO_LUT_DEPTH    4096
`define PXO_PIX_MAX      12'h0FFF
`define PXO_SGAIN_ONE    8'h10
`define PXO_SGAIN_MAX    8'hA0
`define PXO_LGAIN_ONE    8'h20
`define PXO_LGAIN_MAX    8'h80
`define PXO_GAIN_SHIFT   9
`define PXO_GAMMA_RST    8'h10
`define PXO_SLOTS        16
`define PXO_SLOT_W       5
`define PXO_SLOT_FACTORY 5'h00
`define PXO_SYS_TARGET   2'h3
`define PXO_RATE_THREE   9'h064
`define PXO_RATE_TWO     9'h096
`define PXO_RATE_ONE     9'h12C
`define PXO_FIFO_DEPTH   8
`define PXO_FIFO_W       11
`define PXO_SEL_OFFSET   3'h0
`define PXO_SEL_GAIN     3'h1
`define PXO_SEL_LUT      3'h2
`define PXO_SEL_GAMMA    3'h3
`define PXO_SEL_LAYOUT   3'h4
`define PXO_SEL_LINE_EN  3'h5
`define PXO_SEL_CABLE    3'h6
`endif

// ### hdl/pxo_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ns
module pxo_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    wr_d;
  logic [AW-1:0]    rd_q;
  logic [AW-1:0]    rd_d;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_q];

  always_comb begin
    wr_d  = push ? wr_q + 1'b1 : wr_q;
    rd_d  = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage words need no reset
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule // pxo_fifo

// ### hdl/pxo_pkg.sv
// types of the pixel output and configuration set block
`include "pxo_consts.svh"
package pxo_pkg;
  typedef enum logic {
    three_colour_8bit,
    mono_8bit
  } pxo_layout_e;

  typedef struct packed {
    logic signed [`PXO_PIX_W-1:0] ofs;
    logic [7:0]                   sys_gain;
    logic [2:0][7:0]              line_gain;
    logic                         lut_mode;
    logic [7:0]                   gamma;
    pxo_layout_e                  layout;
    logic [2:0]                   line_en;
    logic [1:0]                   next_cable;
  } pxo_set_s;

  localparam pxo_set_s pxo_factory = '{
    ofs:        '0,
    sys_gain:   `PXO_SGAIN_ONE,
    line_gain:  {3{`PXO_LGAIN_ONE}},
    lut_mode:   1'b0,
    gamma:      `PXO_GAMMA_RST,
    layout:     three_colour_8bit,
    line_en:    3'h7,
    next_cable: 2'h0
  };
endpackage

// ### hdl/pxo_top.sv
// pixel processing chain, output layout and configuration slot store
`timescale 1ns/1ns
`include "pxo_consts.svh"
module pxo_top (
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  // pixel input
  input  wire logic                   pix_in_valid,
  output logic                        pix_in_ready,
  input  wire logic [`PXO_PIX_W-1:0]  pix_in_data,
  input  wire logic [1:0]             pix_in_line,
  input  wire logic                   pix_in_last,
  // pixel output to link framer
  output logic                        pix_out_valid,
  input  wire logic                   pix_out_ready,
  output logic [`PXO_OUT_W-1:0]       pix_out_data,
  output logic [1:0]                  pix_out_line,
  output logic                        pix_out_last,
  // setting writes
  input  wire logic                   cfg_wr,
  input  wire logic [2:0]             cfg_sel,
  input  wire logic [11:0]            cfg_data,
  input  wire logic [1:0]             gain_target_select,
  input  wire logic [1:0]             colour_line_select,
  // lookup table upload
  input  wire logic                   lut_wr,
  input  wire logic [`PXO_LUT_IN_W-1:0] lut_addr,
  input  wire logic [15:0]            lut_data,
  input  wire logic                   lut_wide,
  output logic                        lut_reject,
  // configuration slots
  input  wire logic [`PXO_SLOT_W-1:0] config_slot_select,
  input  wire logic [`PXO_SLOT_W-1:0] boot_config_slot,
  input  wire logic                   config_slot_store,
  input  wire logic                   config_slot_restore,
  input  wire logic                   ship_init,
  input  wire logic                   cable_reconnect,
  output logic                        slot_reject,
  output logic [`PXO_SLOT_W-1:0]      cur_slot,
  // active setting status
  output logic signed [`PXO_PIX_W-1:0] black_offset_level,
  output logic                        lookup_table_mode,
  output logic [7:0]                  gamma_curve_value,
  output logic                        output_pixel_layout,
  output logic [2:0]                  colour_line_enable,
  output logic [1:0]                  next_cable_lane_config,
  output logic [8:0]                  line_rate_limit_khz,
  // connector roles
  output logic                        conn1_ctrl_en,
  output logic                        conn1_data_en,
  output logic                        conn2_data_en,
  output logic                        lane_swap
);
  localparam int SW = $bits(pxo_pkg::pxo_set_s);

  // active settings and slot store
  pxo_pkg::pxo_set_s            act_q;
  pxo_pkg::pxo_set_s            act_d;
  pxo_pkg::pxo_set_s            sel_set;
  logic [SW-1:0]                slot_mem [1:`PXO_SLOTS];
  logic                         boot_q;
  logic                         boot_d;
  logic [`PXO_SLOT_W-1:0]       cur_slot_q;
  logic [`PXO_SLOT_W-1:0]       cur_slot_d;
  logic                         slot_reject_q;
  logic                         slot_reject_d;
  logic [1:0]                   cable_q;
  logic [1:0]                   cable_d;
  logic [8:0]                   rate_q;
  logic [8:0]                   rate_d;
  logic                         sel_ok;
  logic                         store_ok;
  logic                         do_restore;
  logic                         do_store;
  logic [`PXO_SLOT_W-1:0]       src_slot;
  logic [7:0]                   gain_in;
  logic [1:0]                   n_lines;

  assign src_slot = boot_q ? boot_config_slot : config_slot_select;
  assign sel_ok   = (src_slot <= `PXO_SLOT_W'(`PXO_SLOTS));
  assign store_ok = (config_slot_select != `PXO_SLOT_FACTORY) &&
                    (config_slot_select <= `PXO_SLOT_W'(`PXO_SLOTS));
  assign do_restore = config_slot_restore && !boot_q && sel_ok;
  assign do_store   = config_slot_store && !boot_q && !config_slot_restore && store_ok;

  always_comb begin
    sel_set = pxo_pkg::pxo_factory;
    if (src_slot != `PXO_SLOT_FACTORY && sel_ok) begin
      sel_set = pxo_pkg::pxo_set_s'(slot_mem[src_slot]);
    end
  end

  always_comb begin
    act_d         = act_q;
    cur_slot_d    = cur_slot_q;
    slot_reject_d = 1'b0;
    boot_d        = 1'b0;
    cable_d       = cable_q;
    gain_in       = cfg_data[7:0];
    if (boot_q) begin
      act_d      = sel_set;
      cur_slot_d = sel_ok ? boot_config_slot : `PXO_SLOT_FACTORY;
      cable_d    = sel_set.next_cable;
    end else if (config_slot_restore) begin
      slot_reject_d = !sel_ok;
      if (sel_ok) begin
        act_d      = sel_set;
        cur_slot_d = config_slot_select;
      end
    end else if (config_slot_store) begin
      slot_reject_d = !store_ok;
      if (store_ok) begin
        cur_slot_d = config_slot_select;
      end
    end else if (cfg_wr) begin
      unique case (cfg_sel)
        `PXO_SEL_OFFSET:  act_d.ofs = cfg_data;
        `PXO_SEL_GAIN: begin
          if (gain_target_select == `PXO_SYS_TARGET) begin
            if (gain_in < `PXO_SGAIN_ONE) gain_in = `PXO_SGAIN_ONE;
            if (gain_in > `PXO_SGAIN_MAX) gain_in = `PXO_SGAIN_MAX;
            act_d.sys_gain = gain_in;
          end else begin
            if (gain_in < `PXO_LGAIN_ONE) gain_in = `PXO_LGAIN_ONE;
            if (gain_in > `PXO_LGAIN_MAX) gain_in = `PXO_LGAIN_MAX;
            act_d.line_gain[gain_target_select] = gain_in;
          end
        end
        `PXO_SEL_LUT:     act_d.lut_mode = cfg_data[0];
        `PXO_SEL_GAMMA:   act_d.gamma = cfg_data[7:0];
        `PXO_SEL_LAYOUT:  act_d.layout = pxo_pkg::pxo_layout_e'(cfg_data[0]);
        `PXO_SEL_LINE_EN: act_d.line_en[colour_line_select] = cfg_data[0];
        `PXO_SEL_CABLE:   act_d.next_cable = cfg_data[1:0];
        default:          act_d = act_q;
      endcase
    end
    if (cable_reconnect && !boot_q) begin
      cable_d = act_q.next_cable;
    end
    n_lines = 2'(act_d.line_en[0]) + 2'(act_d.line_en[1]) + 2'(act_d.line_en[2]);
    if (act_d.layout == pxo_pkg::three_colour_8bit || n_lines == 2'd3) begin
      rate_d = `PXO_RATE_THREE;
    end else if (n_lines == 2'd2) begin
      rate_d = `PXO_RATE_TWO;
    end else begin
      rate_d = `PXO_RATE_ONE;
    end
  end

  // volatile active set, reloaded at each reset release
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_q         <= pxo_pkg::pxo_factory;
      boot_q        <= 1'b1;
      cur_slot_q    <= `PXO_SLOT_FACTORY;
      slot_reject_q <= 1'b0;
      cable_q       <= 2'h0;
      rate_q        <= `PXO_RATE_THREE;
    end else begin
      act_q         <= act_d;
      boot_q        <= boot_d;
      cur_slot_q    <= cur_slot_d;
      slot_reject_q <= slot_reject_d;
      cable_q       <= cable_d;
      rate_q        <= rate_d;
    end
  end

  // non-volatile slots, filled with the factory set when shipped
  always_ff @(posedge sys_clk) begin
    if (ship_init) begin
      for (int i = 1; i <= `PXO_SLOTS; i++) begin
        slot_mem[i] <= pxo_pkg::pxo_factory;
      end
    end else if (do_store) begin
      slot_mem[config_slot_select] <= act_q;
    end
  end

  // lookup table memory, one table shared by all slots
  logic [`PXO_PIX_W-1:0] lut_mem [`PXO_LUT_DEPTH];
  logic                  lut_reject_q;
  logic                  lut_reject_d;
  logic                  lut_take;
  logic [`PXO_PIX_W-1:0] lut_entry;

  assign lut_take     = lut_wr && (cur_slot_q != `PXO_SLOT_FACTORY);
  assign lut_reject_d = lut_wr && (cur_slot_q == `PXO_SLOT_FACTORY);
  assign lut_entry    = lut_wide ? lut_data[15:4] : lut_data[11:0];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lut_reject_q <= 1'b0;
    end else begin
      lut_reject_q <= lut_reject_d;
    end
  end

  // pixel pipeline: offset, gain, table, reduction
  logic                  adv;
  logic                  s1_v_q, s2_v_q, s3_v_q, s4_v_q;
  logic                  s1_v_d, s2_v_d, s3_v_d, s4_v_d;
  logic [1:0]            s1_ln_q, s2_ln_q, s3_ln_q, s4_ln_q;
  logic [1:0]            s1_ln_d, s2_ln_d, s3_ln_d, s4_ln_d;
  logic                  s1_lt_q, s2_lt_q, s3_lt_q, s4_lt_q;
  logic                  s1_lt_d, s2_lt_d, s3_lt_d, s4_lt_d;
  logic [11:0]           s1_px_q, s2_px_q, s3_px_q;
  logic [11:0]           s1_px_d, s2_px_d, s3_px_d;
  logic [7:0]            s4_px_q;
  logic [7:0]            s4_px_d;
  logic [11:0]           lut_rd_q;
  logic signed [13:0]    ofs_sum;
  logic [27:0]           gain_prod;
  logic [7:0]            lg;
  logic [11:0]           s3_val;
  logic                  fifo_in_ready;

  assign adv          = fifo_in_ready || !s4_v_q;
  assign pix_in_ready = adv;
  assign s3_val       = act_q.lut_mode ? lut_rd_q : s3_px_q;

  always_comb begin
    ofs_sum = $signed({2'b00, pix_in_data}) + 14'(act_q.ofs);
    s1_px_d = ofs_sum[13] ? 12'h0000 :
              (ofs_sum[12] ? `PXO_PIX_MAX : ofs_sum[11:0]);
    lg        = (s1_ln_q == 2'h3) ? `PXO_LGAIN_ONE : act_q.line_gain[s1_ln_q];
    gain_prod = 28'(s1_px_q) * 28'(act_q.sys_gain) * 28'(lg);
    s2_px_d   = (|gain_prod[27:21]) ? `PXO_PIX_MAX : gain_prod[20:9];
    s3_px_d   = s2_px_q;
    s4_px_d   = s3_val[11:4];
    s1_v_d    = pix_in_valid;
    s2_v_d    = s1_v_q;
    s3_v_d    = s2_v_q;
    s4_v_d    = s3_v_q && (act_q.layout == pxo_pkg::three_colour_8bit ||
                (s3_ln_q != 2'h3 && act_q.line_en[s3_ln_q]));
    s1_ln_d   = pix_in_line;
    s2_ln_d   = s1_ln_q;
    s3_ln_d   = s2_ln_q;
    s4_ln_d   = s3_ln_q;
    s1_lt_d   = pix_in_last;
    s2_lt_d   = s1_lt_q;
    s3_lt_d   = s2_lt_q;
    s4_lt_d   = s3_lt_q;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {s1_v_q, s2_v_q, s3_v_q, s4_v_q}     <= 4'h0;
      {s1_ln_q, s2_ln_q, s3_ln_q, s4_ln_q} <= 8'h00;
      {s1_lt_q, s2_lt_q, s3_lt_q, s4_lt_q} <= 4'h0;
      {s1_px_q, s2_px_q, s3_px_q}          <= 36'h0_0000_0000;
      s4_px_q                              <= 8'h00;
    end else if (adv) begin
      {s1_v_q, s2_v_q, s3_v_q, s4_v_q}     <= {s1_v_d, s2_v_d, s3_v_d, s4_v_d};
      {s1_ln_q, s2_ln_q, s3_ln_q, s4_ln_q} <= {s1_ln_d, s2_ln_d, s3_ln_d, s4_ln_d};
      {s1_lt_q, s2_lt_q, s3_lt_q, s4_lt_q} <= {s1_lt_d, s2_lt_d, s3_lt_d, s4_lt_d};
      {s1_px_q, s2_px_q, s3_px_q}          <= {s1_px_d, s2_px_d, s3_px_d};
      s4_px_q                              <= s4_px_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (lut_take) begin
      lut_mem[lut_addr] <= lut_entry;
    end
    if (adv) begin
      lut_rd_q <= lut_mem[s2_px_q];
    end
  end

  // output buffer toward the link
  logic [`PXO_FIFO_W-1:0] fifo_out;

  pxo_fifo #(
    .WIDTH(`PXO_FIFO_W),
    .DEPTH(`PXO_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (s4_v_q),
    .in_ready  (fifo_in_ready),
    .in_data   ({s4_lt_q, s4_ln_q, s4_px_q}),
    .out_valid (pix_out_valid),
    .out_ready (pix_out_ready),
    .out_data  (fifo_out)
  );

  assign {pix_out_last, pix_out_line, pix_out_data} = fifo_out;
  // status and connector roles
  assign lut_reject             = lut_reject_q;
  assign slot_reject            = slot_reject_q;
  assign cur_slot               = cur_slot_q;
  assign black_offset_level     = act_q.ofs;
  assign lookup_table_mode      = act_q.lut_mode;
  assign gamma_curve_value      = act_q.gamma;
  assign output_pixel_layout    = act_q.layout;
  assign colour_line_enable     = act_q.line_en;
  assign next_cable_lane_config = act_q.next_cable;
  assign line_rate_limit_khz    = rate_q;
  assign conn1_ctrl_en          = 1'b1;
  assign conn1_data_en          = 1'b1;
  assign conn2_data_en          = cable_q[0];
  assign lane_swap              = cable_q[1];
  // checks
  lut_refuse_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    lut_wr && cur_slot_q == `PXO_SLOT_FACTORY |=> lut_reject && !$past(lut_take))
    else $error("table upload to factory set not refused");
  store_slot_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    do_store |=> cur_slot_q == $past(config_slot_select) &&
      slot_mem[$past(config_slot_select)] == $past(act_q))
    else $error("store did not write or select slot");
  restore_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    do_restore |=> act_q == $past(sel_set) && cur_slot_q == $past(config_slot_select))
    else $error("restore did not load selected set");
  boot_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    boot_q |=> !boot_q && act_q == $past(sel_set) && cable_q == $past(sel_set.next_cable))
    else $error("boot slot not loaded after reset");
  cable_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !boot_q && !cable_reconnect |=> $stable(cable_q))
    else $error("cable setting changed without reconnection");
  sys_gain_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    act_q.sys_gain >= `PXO_SGAIN_ONE && act_q.sys_gain <= `PXO_SGAIN_MAX)
    else $error("system gain out of range");
  line_gain_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    act_q.line_gain[0] inside {[`PXO_LGAIN_ONE:`PXO_LGAIN_MAX]} &&
    act_q.line_gain[1] inside {[`PXO_LGAIN_ONE:`PXO_LGAIN_MAX]} &&
    act_q.line_gain[2] inside {[`PXO_LGAIN_ONE:`PXO_LGAIN_MAX]})
    else $error("line gain out of range");
  rate_three_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    act_q.layout == pxo_pkg::three_colour_8bit ##1 act_q.layout == pxo_pkg::three_colour_8bit
      |-> rate_q == `PXO_RATE_THREE)
    else $error("three colour rate limit wrong");
  mono_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    adv && s3_v_q && act_q.layout == pxo_pkg::mono_8bit && !act_q.line_en[s3_ln_q]
      |=> !s4_v_q)
    else $error("disabled line reached output");
endmodule // pxo_top

// ### verif/pxo_sink.sv
// frame grabber side model that takes pixel words, with stall and slow modes
`timescale 1ns/1ns
`include "pxo_consts.svh"
module pxo_sink (
  // clock
  input  wire logic                  sys_clk,
  // pixel stream from the device
  input  wire logic                  pix_out_valid,
  output logic                       pix_out_ready,
  input  wire logic [`PXO_OUT_W-1:0] pix_out_data,
  // behaviour control
  input  wire logic                  stall,
  input  wire logic                  slow,
  // captured words
  output logic [`PXO_OUT_W-1:0]      rx_mem [64],
  output int                         rx_count
);
  initial begin
    pix_out_ready = 1'b0;
    rx_count      = 0;
  end
  // ready changes only after a falling edge; slow mode takes every other cycle
  always @(negedge sys_clk) begin
    pix_out_ready <= !stall && !(slow && pix_out_ready);
  end
  always @(posedge sys_clk) begin
    if (pix_out_valid && pix_out_ready) begin
      rx_mem[rx_count % 64] <= pix_out_data;
      rx_count              <= rx_count + 1;
    end
  end
endmodule // pxo_sink

// ### verif/tb_pxo_top.sv
// testbench of the pixel output and configuration set block
`timescale 1ns/1ns
`include "pxo_consts.svh"
module tb_pxo_top;
  logic        sys_clk, rst_n, pix_in_valid, pix_in_ready, pix_in_last, pix_out_valid;
  logic        pix_out_ready, pix_out_last, cfg_wr, lut_wr, lut_wide, lut_reject;
  logic        config_slot_store, config_slot_restore, ship_init, cable_reconnect;
  logic        slot_reject, lookup_table_mode, output_pixel_layout, stall, slow, r, rdy;
  logic        conn1_ctrl_en, conn1_data_en, conn2_data_en, lane_swap;
  logic [11:0] pix_in_data, cfg_data, lut_addr;
  logic [15:0] lut_data;
  logic [7:0]  pix_out_data, gamma_curve_value;
  logic [7:0]  rx_mem [64];
  logic [1:0]  pix_in_line, pix_out_line, gain_target_select, colour_line_select;
  logic [1:0]  next_cable_lane_config;
  logic [2:0]  cfg_sel, colour_line_enable;
  logic [4:0]  config_slot_select, boot_config_slot, cur_slot;
  logic [8:0]  line_rate_limit_khz;
  logic signed [11:0] black_offset_level;
  int          n_mismatch, cmp_count, rx_count, b, k, t;

  pxo_top dut (.sys_clk, .rst_n, .pix_in_valid, .pix_in_ready, .pix_in_data, .pix_in_line,
    .pix_in_last, .pix_out_valid, .pix_out_ready, .pix_out_data, .pix_out_line, .pix_out_last,
    .cfg_wr, .cfg_sel, .cfg_data, .gain_target_select, .colour_line_select, .lut_wr, .lut_addr,
    .lut_data, .lut_wide, .lut_reject, .config_slot_select, .boot_config_slot,
    .config_slot_store, .config_slot_restore, .ship_init, .cable_reconnect, .slot_reject,
    .cur_slot, .black_offset_level, .lookup_table_mode, .gamma_curve_value,
    .output_pixel_layout, .colour_line_enable, .next_cable_lane_config, .line_rate_limit_khz,
    .conn1_ctrl_en, .conn1_data_en, .conn2_data_en, .lane_swap);
  pxo_sink grabber (.sys_clk, .pix_out_valid, .pix_out_ready, .pix_out_data, .stall, .slow,
    .rx_mem, .rx_count);

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] pix_exp(int p, int o, int sg, int lg);
    int v;
    v = p + o;
    v = v < 0 ? 0 : (v > `PXO_PIX_MAX ? `PXO_PIX_MAX : v);
    v = (v * sg * lg) >>> `PXO_GAIN_SHIFT;
    v = v > `PXO_PIX_MAX ? `PXO_PIX_MAX : v;
    return v[11:4];
  endfunction

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
  endtask

  task automatic send(input logic [11:0] d, input logic [1:0] ln);
    int w;
    @(negedge sys_clk);
    pix_in_valid = 1'b1;
    pix_in_data  = d;
    pix_in_line  = ln;
    pix_in_last  = 1'b1;
    w = 0;
    while (pix_in_ready !== 1'b1 && w < 100) begin
      @(negedge sys_clk);
      w++;
    end
    @(negedge sys_clk);
    pix_in_valid = 1'b0;
  endtask

  task automatic px(input logic [11:0] d, input logic [1:0] ln, input logic [7:0] e);
    int s;
    int w;
    s = rx_count;
    send(d, ln);
    w = 0;
    while (rx_count == s && w < 50) begin
      @(negedge sys_clk);
      w++;
    end
    chk("pix_out_data", rx_mem[s % 64], e);
  endtask

  task automatic cfg(input logic [2:0] s, input logic [11:0] d);
    @(negedge sys_clk);
    cfg_wr   = 1'b1;
    cfg_sel  = s;
    cfg_data = d;
    @(negedge sys_clk);
    cfg_wr = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic cmd(input logic st, input logic rs, input logic [4:0] s, output logic rj);
    @(negedge sys_clk);
    config_slot_store   = st;
    config_slot_restore = rs;
    config_slot_select  = s;
    @(negedge sys_clk);
    rj                  = slot_reject;
    config_slot_store   = 1'b0;
    config_slot_restore = 1'b0;
  endtask

  task automatic lut(input logic [11:0] a, input logic [15:0] d, input logic w,
                     output logic rj);
    @(negedge sys_clk);
    lut_wr   = 1'b1;
    lut_addr = a;
    lut_data = d;
    lut_wide = w;
    @(negedge sys_clk);
    rj     = lut_reject;
    lut_wr = 1'b0;
  endtask

  initial begin
    #200000;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    {pix_in_valid, pix_in_last, cfg_wr, lut_wr, lut_wide, stall, slow} = '0;
    {config_slot_store, config_slot_restore, ship_init, cable_reconnect} = '0;
    {pix_in_data, pix_in_line, cfg_sel, cfg_data, gain_target_select, colour_line_select} = '0;
    {lut_addr, lut_data, config_slot_select, boot_config_slot} = '0;
    n_mismatch = 0;
    cmp_count  = 0;
    do_reset();
    chk("layout", output_pixel_layout, 1'b0);
    chk("rate", line_rate_limit_khz, `PXO_RATE_THREE);
    chk("gamma", gamma_curve_value, `PXO_GAMMA_RST);
    chk("slot", cur_slot, `PXO_SLOT_FACTORY);
    chk("roles", {conn1_ctrl_en, conn1_data_en, conn2_data_en}, 3'b110);
    @(negedge sys_clk);
    ship_init = 1'b1;
    @(negedge sys_clk);
    ship_init = 1'b0;
    px(12'hABC, 2'd0, pix_exp(12'hABC, 0, 16, 32));
    cfg(`PXO_SEL_OFFSET, 12'h010);
    px(12'hABC, 2'd0, pix_exp(12'hABC, 16, 16, 32));
    cfg(`PXO_SEL_OFFSET, 12'hF00);
    px(12'h050, 2'd0, 8'h00);
    gain_target_select = `PXO_SYS_TARGET;
    cfg(`PXO_SEL_GAIN, 12'h020);
    px(12'h300, 2'd0, pix_exp(12'h300, -256, 32, 32));
    cfg(`PXO_SEL_OFFSET, 12'h000);
    cfg(`PXO_SEL_GAIN, 12'h0FF);
    px(12'h100, 2'd0, pix_exp(12'h100, 0, 160, 32));
    cfg(`PXO_SEL_GAIN, 12'h010);
    gain_target_select = 2'd1;
    cfg(`PXO_SEL_GAIN, 12'h0FF);
    px(12'h100, 2'd1, pix_exp(12'h100, 0, 16, 128));
    lut(12'h100, 16'hFEDC, 1'b1, r);
    chk("lut_reject", r, 1'b1);
    cmd(1'b1, 1'b0, 5'd1, r);
    chk("slot", cur_slot, 5'd1);
    lut(12'h100, 16'hFEDC, 1'b1, r);
    chk("lut_reject", r, 1'b0);
    lut(12'h200, 16'h0123, 1'b0, r);
    cfg(`PXO_SEL_OFFSET, 12'h000);
    cfg(`PXO_SEL_LUT, 12'h001);
    chk("rate", line_rate_limit_khz, `PXO_RATE_THREE);
    px(12'h100, 2'd0, 8'hFE);
    px(12'h200, 2'd0, 8'h12);
    cfg(`PXO_SEL_LUT, 12'h000);
    fork
      px(12'h400, 2'd0, 8'h40);
      cfg(`PXO_SEL_GAMMA, 12'h033);
    join
    chk("gamma", gamma_curve_value, 8'h33);
    cfg(3'h7, 12'h0FF);
    chk("ignored", {gamma_curve_value, output_pixel_layout}, {8'h33, 1'b0});
    cfg(`PXO_SEL_LAYOUT, 12'h001);
    chk("layout", output_pixel_layout, 1'b1);
    chk("rate", line_rate_limit_khz, `PXO_RATE_THREE);
    colour_line_select = 2'd1;
    cfg(`PXO_SEL_LINE_EN, 12'h000);
    chk("rate", line_rate_limit_khz, `PXO_RATE_TWO);
    b = rx_count;
    send(12'h800, 2'd1);
    px(12'h300, 2'd0, 8'h30);
    chk("count", rx_count - b, 1);
    colour_line_select = 2'd2;
    cfg(`PXO_SEL_LINE_EN, 12'h000);
    chk("rate", line_rate_limit_khz, `PXO_RATE_ONE);
    cfg(`PXO_SEL_LAYOUT, 12'h000);
    chk("rate", line_rate_limit_khz, `PXO_RATE_THREE);
    px(12'h500, 2'd2, 8'h50);
    cmd(1'b1, 1'b0, 5'd2, r);
    cfg(`PXO_SEL_GAMMA, 12'h055);
    cmd(1'b0, 1'b1, 5'd2, r);
    chk("gamma", gamma_curve_value, 8'h33);
    cmd(1'b0, 1'b1, 5'd5, r);
    chk("lines", {gamma_curve_value, colour_line_enable}, {`PXO_GAMMA_RST, 3'h7});
    chk("slot", cur_slot, 5'd5);
    cmd(1'b0, 1'b1, 5'd0, r);
    chk("slot", cur_slot, 5'd0);
    cmd(1'b0, 1'b1, 5'd17, r);
    chk("slot_reject", r, 1'b1);
    cmd(1'b1, 1'b0, 5'd0, r);
    chk("slot_reject", r, 1'b1);
    cfg(`PXO_SEL_CABLE, 12'h003);
    chk("next_cable", next_cable_lane_config, 2'h3);
    chk("cable", {conn2_data_en, lane_swap}, 2'b00);
    @(negedge sys_clk);
    cable_reconnect = 1'b1;
    @(negedge sys_clk);
    cable_reconnect = 1'b0;
    chk("cable", {conn2_data_en, lane_swap}, 2'b11);
    stall = 1'b1;
    b     = rx_count;
    k     = 0;
    @(negedge sys_clk);
    pix_in_valid = 1'b1;
    pix_in_data  = 12'h000;
    {pix_in_line, pix_in_last} = 3'b100;
    rdy          = pix_in_ready;
    repeat (30) begin
      @(negedge sys_clk);
      if (rdy === 1'b1) begin
        k++;
        pix_in_data = 12'(k * 16);
      end
      rdy = pix_in_ready;
    end
    pix_in_valid = 1'b0;
    chk("pix_in_ready", pix_in_ready, 1'b0);
    chk("taken", k, `PXO_FIFO_DEPTH + 4);
    chk("pix_out_side", {pix_out_last, pix_out_line, pix_out_data}, 11'h200);
    stall = 1'b0;
    slow  = 1'b1;
    t     = 0;
    while (rx_count - b < k && t < 200) begin
      @(negedge sys_clk);
      t++;
    end
    for (int i = 0; i < k; i++) chk("fifo order", rx_mem[(b + i) % 64], i);
    repeat (3) @(negedge sys_clk);
    chk("pix_out_valid", pix_out_valid, 1'b0);
    cfg(`PXO_SEL_GAMMA, 12'h055);
    boot_config_slot = 5'd2;
    do_reset();
    chk("gamma", gamma_curve_value, 8'h33);
    chk("slot", cur_slot, 5'd2);
    chk("lines", colour_line_enable, 3'h1);
    give_verdict();
  end
endmodule // tb_pxo_top
